//--- inc/pbgci_if.sv
// Internal carriers: register access and change detection
`timescale 1ns/1ps
interface pbgci_reg_if;
	logic       wr;
	logic [7:0] widx;
	logic [7:0] wdata;
	logic       whit;
	logic       rd;
	logic [7:0] ridx;
	logic [7:0] rdata;
	logic       rhit;
	modport slave (output wr, widx, wdata, rd, ridx,
		input whit, rdata, rhit);
	modport regs (input wr, widx, wdata, rd, ridx,
		output whit, rdata, rhit);
endinterface : pbgci_reg_if

interface pbgci_chg_if;
	logic [3:0] pins;
	logic [3:0] is_input;
	logic       refresh;
	logic       mismatch;
	modport det (input pins, is_input, refresh, output mismatch);
	modport ctl (output pins, is_input, refresh, input mismatch);
endinterface : pbgci_chg_if

//--- inc/pbgci_pkg.sv
// Constants and helpers shared by the port B GPIO block
package pbgci_pkg;

	localparam int          PIN_N        = 8;
	localparam int          DATA_W       = 8;
	localparam int          AXI_DATA_W   = 32;
	localparam int          ADDR_W       = 12;
	localparam int          IDX_W        = 8;
	localparam int          IDX_LO       = 2;
	localparam int          IDX_HI       = IDX_LO + IDX_W - 1;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_PORT     = 8'h06;
	localparam logic [7:0]  IDX_OPTION   = 8'h81;
	localparam logic [7:0]  IDX_DIR      = 8'h86;
	localparam logic [7:0]  IDX_INTCTL   = 8'h0B;

	// Reset values
	localparam logic [7:0]  DIR_RST      = 8'hFF;
	localparam logic [7:0]  OPTION_RST   = 8'hFF;

	// Field positions
	localparam int          OPT_PULLUP_N = 7;
	localparam int          INTCTL_FLAG  = 0;

	// Pin roles
	localparam int          PIN_EXT_IRQ  = 0;
	localparam int          PIN_TMR_OUT  = 1;
	localparam int          PIN_TMR_IN   = 2;
	localparam int          PIN_CCP      = 3;
	localparam int          CHG_LO       = 4;
	localparam int          CHG_N        = 4;
	localparam int          PIN_PROG_CLK = 6;
	localparam int          PIN_PROG_DAT = 7;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	function automatic logic pbgci_is_mapped(input logic [7:0] idx);
		pbgci_is_mapped = (idx == IDX_PORT) || (idx == IDX_OPTION) ||
			(idx == IDX_DIR) || (idx == IDX_INTCTL);
	endfunction : pbgci_is_mapped

endpackage : pbgci_pkg

//--- rtl/pbgci_axil_slave.sv
// AXI4-Lite slave front end for the port B registers
`timescale 1ns/1ps
module pbgci_axil_slave
	import pbgci_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  s_axi_awvalid,
	output      logic                  s_axi_awready,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_wvalid,
	output      logic                  s_axi_wready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	output      logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output      logic [1:0]            s_axi_bresp,
	input  wire logic                  s_axi_arvalid,
	output      logic                  s_axi_arready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	output      logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output      logic [AXI_DATA_W-1:0] s_axi_rdata,
	output      logic [1:0]            s_axi_rresp,
	pbgci_reg_if.slave                 bus
);

	typedef struct packed {
		logic                  awready;
		logic                  aw_held;
		logic [7:0]            widx;
		logic                  wok;
		logic                  wready;
		logic                  w_held;
		logic [7:0]            wdata;
		logic                  wen;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  wr;
		logic                  arready;
		logic                  ar_held;
		logic [7:0]            ridx;
		logic                  rok;
		logic                  rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
		logic                  rd;
	} pbgci_axil_t;

	pbgci_axil_t st;
	pbgci_axil_t next_st;

	function automatic logic in_range(input logic [ADDR_W-1:0] a);
		in_range = (a[ADDR_W-1:IDX_HI+1] == '0) && (a[IDX_LO-1:0] == '0);
	endfunction : in_range

	always_comb begin
		next_st = st;
		next_st.wr = 1'b0;
		next_st.rd = 1'b0;
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.widx = s_axi_awaddr[IDX_HI:IDX_LO];
			next_st.wok = in_range(s_axi_awaddr);
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata[DATA_W-1:0];
			next_st.wen = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		// Both halves held: answer and fire the register write
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = (st.wok && bus.whit) ? RESP_OKAY : RESP_SLVERR;
			next_st.wr = st.wen && st.wok && bus.whit;
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.ar_held = 1'b1;
			next_st.ridx = s_axi_araddr[IDX_HI:IDX_LO];
			next_st.rok = in_range(s_axi_araddr);
		end
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (st.ar_held && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = (st.rok && bus.rhit) ?
				AXI_DATA_W'(bus.rdata) : '0;
			next_st.rresp = (st.rok && bus.rhit) ? RESP_OKAY : RESP_SLVERR;
			next_st.rd = st.rok && bus.rhit;
			next_st.ar_held = 1'b0;
		end
		next_st.awready = !next_st.aw_held;
		next_st.wready = !next_st.w_held;
		next_st.arready = !next_st.ar_held;
		if (!aresetn)
			next_st = '0;
	end

	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign bus.wr        = st.wr;
	assign bus.widx      = st.widx;
	assign bus.wdata     = st.wdata;
	assign bus.rd        = st.rd;
	assign bus.ridx      = st.ridx;

	a_bvalid_held: assert property (@(posedge aclk) disable iff (!aresetn)
		st.bvalid && !s_axi_bready |=> st.bvalid)
		else $error("write response dropped before bready");
	a_read_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		st.rd |-> st.rvalid && $past(st.ar_held))
		else $error("register read strobe without read answer");

endmodule : pbgci_axil_slave

//--- rtl/pbgci_change_det.sv
// Change detector for the upper four port pins
`timescale 1ns/1ps
module pbgci_change_det
	import pbgci_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	pbgci_chg_if.det  chg
);

	typedef struct packed {
		logic [CHG_N-1:0] ref_val;
		logic             mismatch;
	} pbgci_chg_t;

	pbgci_chg_t st;
	pbgci_chg_t next_st;

	always_comb begin
		next_st = st;
		// Output pins are masked out of the comparison
		next_st.mismatch = !chg.refresh &&
			(|((chg.pins ^ st.ref_val) & chg.is_input));
		if (chg.refresh || !aresetn)
			next_st.ref_val = chg.pins;
		if (!aresetn)
			next_st.mismatch = 1'b0;
	end

	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	assign chg.mismatch = st.mismatch;

	a_refresh_ends: assert property (@(posedge aclk) disable iff (!aresetn)
		chg.refresh |=> !chg.mismatch)
		else $error("mismatch seen right after reference refresh");
	a_outputs_ignored: assert property (@(posedge aclk)
		disable iff (!aresetn)
		chg.is_input == '0 |=> !chg.mismatch)
		else $error("output pin took part in change compare");

endmodule : pbgci_change_det

//--- rtl/pbgci_top.sv
// Port B GPIO with pull-ups, overrides and change detection
//
// Functional notes
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero drives the output latch onto the pin.
// - Eight bidirectional pins, each with data and direction bit.
// - Clearing option bit 7 turns on all weak pull-ups together.
// - Pins acting as outputs never have their pull-up on.
// - Pull-ups are off after reset.
// - An enabled peripheral overrides the pin direction bit.
// - Only input pins among bits 4 to 7 take part in change compare.
// - Reference for the compare is latched from the pins on port read.
// - Mismatches are ORed to set the port change flag, bit 0.
// - A port change can wake the device from sleep.
// - Any port read or write refreshes the reference, ending mismatch.
// - A lasting mismatch keeps setting the flag every cycle.
// - Pin 0 also feeds the external interrupt input.
// - Pin 3 also serves capture input, compare or PWM output.
// - Pins 1 and 2 carry timer oscillator; pin 1 also timer clock.
// - Pins 6 and 7 serve as programming clock and data.
// - Reset loads direction and option all ones; latch stays.
`timescale 1ns/1ps
module pbgci_top
	import pbgci_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  s_axi_awvalid,
	output      logic                  s_axi_awready,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_wvalid,
	output      logic                  s_axi_wready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	output      logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output      logic [1:0]            s_axi_bresp,
	input  wire logic                  s_axi_arvalid,
	output      logic                  s_axi_arready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	output      logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output      logic [AXI_DATA_W-1:0] s_axi_rdata,
	output      logic [1:0]            s_axi_rresp,
	input  wire logic [PIN_N-1:0]      pin_in,
	output      logic [PIN_N-1:0]      pin_out,
	output      logic [PIN_N-1:0]      pin_oe_n,
	output      logic [PIN_N-1:0]      pullup_en,
	input  wire logic                  timer_osc_enable,
	input  wire logic                  ccp_capture_enable,
	input  wire logic                  ccp_drive_enable,
	input  wire logic                  ccp_out,
	input  wire logic                  prog_mode,
	input  wire logic                  prog_data_drive,
	input  wire logic                  prog_data_out,
	input  wire logic                  sleep_mode,
	output      logic                  ext_irq_in,
	output      logic                  timer_clk_in,
	output      logic                  timer_osc_in,
	output      logic                  capture_in,
	output      logic                  prog_clock_in,
	output      logic                  prog_data_in,
	output      logic                  port_change_flag,
	output      logic                  wake_req
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [PIN_N-1:0] latch;
		logic [PIN_N-1:0] dir;
		logic [PIN_N-1:0] option;
		logic             flag;
		logic [PIN_N-1:0] pin_out;
		logic [PIN_N-1:0] pin_oe_n;
		logic [PIN_N-1:0] pullup_en;
		logic             ext_irq_in;
		logic             timer_clk_in;
		logic             timer_osc_in;
		logic             capture_in;
		logic             prog_clock_in;
		logic             prog_data_in;
		logic             wake;
	} pbgci_top_t;

	pbgci_top_t       st;
	pbgci_top_t       next_st;
	logic [PIN_N-1:0] eff_dir;
	logic [PIN_N-1:0] drive_val;
	logic             port_wr;
	logic             port_rd;
	logic [7:0]       read_val;

	pbgci_reg_if bus ();
	pbgci_chg_if chg ();

	////////////////////////////////////////////////////////////////////////
	// Bus slave and change detector

	pbgci_axil_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.bus           (bus)
	);

	pbgci_change_det u_chg (
		.aclk    (aclk),
		.aresetn (aresetn),
		.chg     (chg)
	);

	////////////////////////////////////////////////////////////////////////
	// Register decode and read mux

	assign bus.whit = pbgci_is_mapped(bus.widx);
	assign bus.rhit = pbgci_is_mapped(bus.ridx);
	assign port_wr  = bus.wr && (bus.widx == IDX_PORT);
	assign port_rd  = bus.rd && (bus.ridx == IDX_PORT);

	always_comb begin
		read_val = '0;
		case (bus.ridx)
			IDX_PORT:   read_val = pin_in;
			IDX_OPTION: read_val = st.option;
			IDX_DIR:    read_val = st.dir;
			IDX_INTCTL: read_val[INTCTL_FLAG] = st.flag;
			default:    read_val = '0;
		endcase
	end
	assign bus.rdata = read_val;

	////////////////////////////////////////////////////////////////////////
	// Change detector hookup

	assign chg.pins     = pin_in[CHG_LO +: CHG_N];
	assign chg.is_input = eff_dir[CHG_LO +: CHG_N];
	assign chg.refresh  = port_rd || port_wr;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st = st;
		// Plain latch and direction per pin before overrides
		for (int i = 0; i < PIN_N; i++) begin
			eff_dir[i] = st.dir[i];
			drive_val[i] = st.latch[i];
		end
		// Peripheral overrides win over the direction bits
		if (timer_osc_enable) begin
			eff_dir[PIN_TMR_OUT] = 1'b1;
			eff_dir[PIN_TMR_IN] = 1'b1;
		end
		if (ccp_capture_enable) begin
			eff_dir[PIN_CCP] = 1'b1;
		end else if (ccp_drive_enable) begin
			eff_dir[PIN_CCP] = 1'b0;
			drive_val[PIN_CCP] = ccp_out;
		end
		if (prog_mode) begin
			eff_dir[PIN_PROG_CLK] = 1'b1;
			eff_dir[PIN_PROG_DAT] = !prog_data_drive;
			drive_val[PIN_PROG_DAT] = prog_data_out;
		end

		// Register writes
		if (bus.wr) begin
			case (bus.widx)
				IDX_PORT:   next_st.latch = bus.wdata;
				IDX_OPTION: next_st.option = bus.wdata;
				IDX_DIR:    next_st.dir = bus.wdata;
				IDX_INTCTL: next_st.flag = bus.wdata[INTCTL_FLAG];
				default:    next_st.flag = st.flag;
			endcase
		end
		// Hardware set beats a software clear in the same cycle
		if (chg.mismatch)
			next_st.flag = 1'b1;
		next_st.wake = chg.mismatch && sleep_mode;

		// Pin drivers; input pins drive low behind a released enable
		next_st.pin_oe_n = eff_dir;
		next_st.pin_out = drive_val & ~eff_dir;
		next_st.pullup_en = {PIN_N{!st.option[OPT_PULLUP_N]}} &
			eff_dir;

		// Alternate-function inputs
		next_st.ext_irq_in = pin_in[PIN_EXT_IRQ];
		next_st.timer_clk_in = pin_in[PIN_TMR_OUT];
		next_st.timer_osc_in = pin_in[PIN_TMR_IN];
		next_st.capture_in = pin_in[PIN_CCP];
		next_st.prog_clock_in = pin_in[PIN_PROG_CLK];
		next_st.prog_data_in = pin_in[PIN_PROG_DAT];

		if (!aresetn) begin
			next_st = '0;
			next_st.latch = st.latch;
			next_st.dir = DIR_RST;
			next_st.option = OPTION_RST;
			next_st.pin_oe_n = DIR_RST;
		end
	end

	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign pin_out          = st.pin_out;
	assign pin_oe_n         = st.pin_oe_n;
	assign pullup_en        = st.pullup_en;
	assign ext_irq_in       = st.ext_irq_in;
	assign timer_clk_in     = st.timer_clk_in;
	assign timer_osc_in     = st.timer_osc_in;
	assign capture_in       = st.capture_in;
	assign prog_clock_in    = st.prog_clock_in;
	assign prog_data_in     = st.prog_data_in;
	assign port_change_flag = st.flag;
	assign wake_req         = st.wake;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_oe_follows_dir: assert property (@(posedge aclk)
		disable iff (!aresetn)
		##1 pin_oe_n == $past(eff_dir))
		else $error("pin enable does not follow effective direction");

	a_out_drives_latch: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(!prog_mode && !st.dir[CHG_LO + 1]) ##1 !port_wr
		|-> pin_out[CHG_LO + 1] == $past(st.latch[CHG_LO + 1]))
		else $error("output pin does not drive its latch");

	a_pullup_rule: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!st.option[OPT_PULLUP_N] |=>
		pullup_en == $past(eff_dir))
		else $error("pull-ups disagree with enable and direction");

	a_pullup_output_off: assert property (@(posedge aclk)
		disable iff (!aresetn)
		##1 (pullup_en & ~pin_oe_n) == '0)
		else $error("pull-up on while pin drives");

	a_reset_defaults: assert property (@(posedge aclk)
		$fell(aresetn) |=> st.dir == DIR_RST &&
		st.option == OPTION_RST && pullup_en == '0)
		else $error("reset left direction or pull-ups wrong");

	a_timer_override: assert property (@(posedge aclk)
		disable iff (!aresetn)
		timer_osc_enable |=>
		pin_oe_n[PIN_TMR_IN] && pin_oe_n[PIN_TMR_OUT])
		else $error("timer oscillator pins not forced to input");

	a_ccp_override: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(!ccp_capture_enable && ccp_drive_enable) |=>
		!pin_oe_n[PIN_CCP] && pin_out[PIN_CCP] == $past(ccp_out))
		else $error("compare output not driven on its pin");

	a_flag_sticks: assert property (@(posedge aclk)
		disable iff (!aresetn)
		chg.mismatch |=> port_change_flag)
		else $error("port change flag not set by mismatch");

	a_flag_holds: assert property (@(posedge aclk)
		disable iff (!aresetn)
		port_change_flag && !chg.mismatch &&
		!(bus.wr && bus.widx == IDX_INTCTL) |=> port_change_flag)
		else $error("port change flag lost without clear");

	a_wake_on_change: assert property (@(posedge aclk)
		disable iff (!aresetn)
		chg.mismatch && sleep_mode |=> wake_req)
		else $error("no wake request on port change in sleep");

	a_port_read_pins: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == ADDR_W'({IDX_PORT, 2'h0}) ##1 1'b1
		|=> s_axi_rvalid &&
		s_axi_rdata[DATA_W-1:0] == $past(pin_in))
		else $error("port read does not show pin levels");

	a_ext_irq_follow: assert property (@(posedge aclk)
		disable iff (!aresetn)
		aresetn |=> ext_irq_in == $past(pin_in[PIN_EXT_IRQ]))
		else $error("external interrupt input not following pin 0");

endmodule : pbgci_top

//--- testbench/pbgci_pads.sv
// Pad model: pin levels from drivers, keys and pull-ups
`timescale 1ns/1ps
module pbgci_pads
	import pbgci_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic [PIN_N-1:0] pin_out,
	input  wire logic [PIN_N-1:0] pin_oe_n,
	input  wire logic [PIN_N-1:0] pullup_en,
	input  wire logic [PIN_N-1:0] key_en,
	input  wire logic [PIN_N-1:0] key_lvl,
	output      logic [PIN_N-1:0] pin_in
);
	logic [PIN_N-1:0] flt = 8'h55;
	// Undriven pins wander so a stale level never reads as valid
	always @(posedge aclk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < PIN_N; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (key_en[i])
				pin_in[i] = key_lvl[i];
			else if (pullup_en[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = flt[i];
		end
	end
endmodule : pbgci_pads

//--- testbench/tb_top.sv
// Self-checking bench for the port B GPIO block
`timescale 1ns/1ps
`define CHK(g, e) cmp(34'(g), 34'(e))
module tb_top
	import pbgci_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
	logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [PIN_N-1:0]      pin_in, pin_out, pin_oe_n, pullup_en;
	logic [PIN_N-1:0]      key_en, key_lvl;
	logic timer_osc_enable, ccp_capture_enable, ccp_drive_enable, ccp_out;
	logic prog_mode, prog_data_drive, prog_data_out, sleep_mode;
	logic ext_irq_in, timer_clk_in, timer_osc_in, capture_in;
	logic prog_clock_in, prog_data_in, port_change_flag, wake_req;
	logic [31:0] v;
	int          n_fail, samples_checked;
	logic [1:0]  qb[$];
	logic [33:0] qr[$];

	pbgci_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_in, .pin_out,
		.pin_oe_n, .pullup_en, .timer_osc_enable, .ccp_capture_enable,
		.ccp_drive_enable, .ccp_out, .prog_mode, .prog_data_drive,
		.prog_data_out, .sleep_mode, .ext_irq_in, .timer_clk_in,
		.timer_osc_in, .capture_in, .prog_clock_in, .prog_data_in,
		.port_change_flag, .wake_req);
	pbgci_pads pads (.aclk, .pin_out, .pin_oe_n, .pullup_en, .key_en,
		.key_lvl, .pin_in);

	always #5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////
	function automatic logic [ADDR_W-1:0] ad(input logic [7:0] i);
		ad = ADDR_W'({i, 2'b00});
	endfunction : ad

	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : cmp

	task automatic conclude;
		$display("checked %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_awaddr  <= ad(i);
		s_axi_wdata   <= {24'h000000, d};
		s_axi_bready  <= 1'b1;
		qb.push_back(r);
		fork
			begin
				do @(posedge aclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= ad(i);
		s_axi_rready  <= 1'b1;
		qr.push_back({r, 24'h000000, d});
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	// Response checker: oldest note against each answer
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			`CHK(s_axi_bresp, qb.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			`CHK({s_axi_rresp, s_axi_rdata}, qr.pop_front());
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, timer_osc_enable, ccp_out} = '0;
		{ccp_capture_enable, ccp_drive_enable, prog_mode} = '0;
		{prog_data_drive, prog_data_out, sleep_mode} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		key_en = 8'hFF;
		key_lvl = 8'h00;
		n_fail = 0;
		samples_checked = 0;
		v = $urandom(32'h2DC410E3);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(pin_oe_n, 8'hFF);
		`CHK(pullup_en, 8'h00);
		rd(IDX_OPTION, 8'hFF, RESP_OKAY);
		rd(IDX_DIR, 8'hFF, RESP_OKAY);
		rd(IDX_INTCTL, 8'h00, RESP_OKAY);
		$display("reset test done");
		key_lvl <= 8'h0C;
		wr(IDX_PORT, 8'hA5, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK({pin_oe_n, pin_out}, 16'hFF00);
		wr(IDX_DIR, 8'h0F, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK({pin_oe_n, pin_out}, 16'h0FA0);
		rd(IDX_PORT, 8'hAC, RESP_OKAY);
		key_en <= 8'hF0;
		wr(IDX_OPTION, 8'h7F, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pullup_en, 8'h0F);
		rd(IDX_PORT, 8'hAF, RESP_OKAY);
		key_en <= 8'hFF;
		wr(IDX_OPTION, 8'hFF, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pullup_en, 8'h00);
		$display("direction and pull-up test done");
		wr(IDX_DIR, 8'h00, RESP_OKAY);
		{timer_osc_enable, ccp_drive_enable, ccp_out} <= 3'b111;
		{prog_mode, prog_data_drive, prog_data_out} <= 3'b110;
		v = $urandom;
		key_lvl <= v[7:0];
		repeat (3) @(posedge aclk);
		`CHK(pin_oe_n, 8'h46);
		`CHK({pin_out[7], pin_out[3]}, 2'b01);
		`CHK({prog_data_in, prog_clock_in, capture_in, timer_osc_in,
			timer_clk_in, ext_irq_in}, {pin_in[7:6], pin_in[3:0]});
		{ccp_capture_enable, prog_data_drive} <= 2'b10;
		repeat (3) @(posedge aclk);
		`CHK(pin_oe_n[3], 1'b1);
		`CHK(pin_oe_n[7], 1'b1);
		{timer_osc_enable, ccp_drive_enable, ccp_capture_enable} <= '0;
		{prog_mode, prog_data_drive} <= '0;
		for (int k = 0; k < 4; k++) begin
			v = $urandom;
			wr(IDX_PORT, v[7:0], RESP_OKAY);
			repeat (3) @(posedge aclk);
			`CHK(pin_out, v[7:0]);
			rd(IDX_PORT, v[7:0], RESP_OKAY);
		end
		$display("override test done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK({pin_oe_n, pullup_en}, 16'hFF00);
		wr(IDX_DIR, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pin_out, v[7:0]);
		$display("mid-run reset test done");
		wr(IDX_DIR, 8'hFF, RESP_OKAY);
		key_lvl <= 8'h00;
		rd(IDX_PORT, 8'h00, RESP_OKAY);
		wr(IDX_INTCTL, 8'h00, RESP_OKAY);
		key_lvl <= 8'h04;
		repeat (5) @(posedge aclk);
		`CHK(port_change_flag, 1'b0);
		key_lvl <= 8'h24;
		repeat (5) @(posedge aclk);
		`CHK(port_change_flag, 1'b1);
		wr(IDX_INTCTL, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(port_change_flag, 1'b1);
		rd(IDX_INTCTL, 8'h01, RESP_OKAY);
		rd(IDX_PORT, 8'h24, RESP_OKAY);
		wr(IDX_INTCTL, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(port_change_flag, 1'b0);
		wr(IDX_PORT, 8'h10, RESP_OKAY);
		wr(IDX_DIR, 8'hEF, RESP_OKAY);
		repeat (5) @(posedge aclk);
		`CHK(port_change_flag, 1'b0);
		wr(IDX_DIR, 8'hFF, RESP_OKAY);
		key_lvl <= 8'h84;
		repeat (5) @(posedge aclk);
		wr(IDX_PORT, 8'h00, RESP_OKAY);
		wr(IDX_INTCTL, 8'h00, RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(port_change_flag, 1'b0);
		sleep_mode <= 1'b1;
		key_lvl <= 8'hC4;
		for (int k = 0; k < 8 && wake_req !== 1'b1; k++)
			@(posedge aclk);
		`CHK(wake_req, 1'b1);
		sleep_mode <= 1'b0;
		$display("change test done");
		wr(8'h40, 8'h55, RESP_SLVERR);
		rd(8'h40, 8'h00, RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(IDX_OPTION, 8'h00, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(IDX_OPTION, 8'hFF, RESP_OKAY);
		rd(IDX_PORT, 8'hC4, RESP_OKAY);
		$display("unmapped test done");
		conclude();
	end
endmodule : tb_top
